// ===== bench/dac_model.sv
// Converter model that receives the serial stereo stream
`timescale 1ns/1ns
`default_nettype none
module dac_model (
    input  wire logic        bit_clk_in,
    input  wire logic        word_clk_in,
    input  wire logic        data_in,
    output logic      [15:0] left_out,
    output logic      [15:0] right_out
);
    logic [15:0] shift_reg;
    int          bit_reg = 0;
    logic        ws_reg = 1'b0;
    // Rising edge sampling, away from the sender's falling edge
    always @(posedge bit_clk_in) begin
        if (word_clk_in !== ws_reg) bit_reg = 0;
        shift_reg[bit_reg[3:0]] = data_in;
        bit_reg++;
        if (bit_reg == 16 && word_clk_in) right_out = shift_reg;
        if (bit_reg == 16 && !word_clk_in) left_out = shift_reg;
        ws_reg = word_clk_in;
    end
endmodule
`default_nettype wire

// ===== bench/stereo_pcm_serial_output_asserts.sv
// Port checker for the stereo PCM serial output
`timescale 1ns/1ns
`default_nettype none
module pcm_out_checker #(
    parameter int CLKS_PER_FRAME = 256
) (
    input wire logic         ref_clk_in,
    input wire logic         rstn_in,
    input wire logic         link_clk_in,
    input wire logic [127:0] voice_samples_in,
    input wire logic         sample_request_out,
    input wire logic [15:0]  section_end_out,
    input wire logic         serial_bit_clock_out,
    input wire logic [2:0]   converter_port_pins_out
);
    int          gap_reg;
    logic        gap_seen_reg, ws_seen_reg;
    logic [3:0]  ws_cnt_reg;
    logic [1:0]  rise_reg;
    logic [15:0] ends;
    always_comb for (int v = 0; v < 16; v++) ends[v] = voice_samples_in[v*8+:8] == 8'h80;
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        gap_reg <= !rstn_in || sample_request_out ? 0 : gap_reg + 1;
        gap_seen_reg <= rstn_in && (gap_seen_reg || sample_request_out);
    end
    // Word clock length counted on the sender's edge
    always_ff @(negedge link_clk_in or negedge rstn_in) begin
        ws_cnt_reg <= !rstn_in || $changed(converter_port_pins_out[1]) ? 4'h0 : ws_cnt_reg + 4'h1;
        ws_seen_reg <= rstn_in && (ws_seen_reg || $changed(converter_port_pins_out[1]));
    end
    always_ff @(posedge link_clk_in or negedge rstn_in) rise_reg <= rstn_in ? converter_port_pins_out[2:1] : 2'h0;
    sequence req_then_take;
        sample_request_out ##3 1;
    endsequence
    req_pulse_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        sample_request_out |=> !sample_request_out) else $error("request too long");
    req_period_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        sample_request_out && gap_seen_reg |-> gap_reg == CLKS_PER_FRAME - 1) else $error("request period");
    bit_clock_fwd_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        serial_bit_clock_out == link_clk_in) else $error("bit clock");
    pin_clock_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        converter_port_pins_out[0] == link_clk_in) else $error("pin map");
    fall_only_a: assert property (@(negedge link_clk_in) disable iff (!rstn_in)
        converter_port_pins_out[2:1] == rise_reg) else $error("moved on rising edge");
    word_len_a: assert property (@(negedge link_clk_in) disable iff (!rstn_in)
        $changed(converter_port_pins_out[1]) && ws_seen_reg |-> ws_cnt_reg == 4'hf) else $error("word length");
    end_flags_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        req_then_take |-> section_end_out == $past(ends, 3)) else $error("end flags");
    end_hold_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        !$past(sample_request_out) && !$past(sample_request_out, 2) && !$past(sample_request_out, 3)
        |-> $stable(section_end_out)) else $error("end flags moved");
endmodule
bind stereo_pcm_serial_output pcm_out_checker #(.CLKS_PER_FRAME(CLKS_PER_FRAME)) chk (.ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in), .link_clk_in(link_clk_in), .voice_samples_in(voice_samples_in),
    .sample_request_out(sample_request_out), .section_end_out(section_end_out),
    .serial_bit_clock_out(serial_bit_clock_out), .converter_port_pins_out(converter_port_pins_out));
`default_nettype wire

// ===== bench/test_stereo_pcm_serial_output.sv
// Self-checking bench for the stereo PCM serial output
`timescale 1ns/1ns
`default_nettype none
module test_stereo_pcm_serial_output;
    logic         ref_clk_in, rstn_in, link_clk_in, req, bclk;
    logic [127:0] voices;
    logic [15:0]  ends, left, right;
    logic [2:0]   pins;
    int           num_errors = 0, samples_checked = 0, cycles = 0;
    stereo_pcm_serial_output dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .link_clk_in(link_clk_in),
        .voice_samples_in(voices), .sample_request_out(req), .section_end_out(ends),
        .serial_bit_clock_out(bclk), .converter_port_pins_out(pins));
    dac_model dac (.bit_clk_in(bclk), .word_clk_in(pins[1]), .data_in(pins[2]), .left_out(left), .right_out(right));
    initial begin
        ref_clk_in = 1'b0;
        forever #4 ref_clk_in = ~ref_clk_in;
    end
    initial begin
        link_clk_in = 1'b0;
        #3;
        forever #6 link_clk_in = ~link_clk_in;
    end
    task automatic conclude;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge ref_clk_in) if (++cycles == 12000) begin
        num_errors++;
        conclude();
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Expected mix wraps in 16 bits; end markers add nothing
    task automatic play(input logic [127:0] v);
        logic [15:0] mix, fl;
        mix = 16'h0;
        fl = 16'h0;
        for (int i = 0; i < 16; i++) if (v[i*8+:8] == 8'h80) fl[i] = 1'b1; else mix += {{8{v[i*8+7]}}, v[i*8+:8]};
        @(posedge ref_clk_in) #1 voices = v;
        repeat (2) @(posedge req);
        #1500;
        chk("left", mix, left);
        chk("right", mix, right);
        chk("ends", fl, ends);
    endtask
    task automatic ramp_voices;
        logic [127:0] v;
        for (int i = 0; i < 16; i++) v[i*8+:8] = 8'(i + 1);
        play(v);
    endtask
    task automatic negative_voices;
        play({16{8'hff}});
    endtask
    task automatic end_markers;
        play({8{8'h7f, 8'h80}});
        play({16{8'h80}});
    endtask
    task automatic bit_order;
        play({120'h0, 8'h01});
        play({16{8'h81}});
    endtask
    initial begin
        rstn_in = 1'b0;
        voices = 128'h0;
        repeat (20) @(posedge ref_clk_in);
        #1 rstn_in = 1'b1;
        ramp_voices();
        negative_voices();
        end_markers();
        bit_order();
        conclude();
    end
endmodule
`default_nettype wire

// ===== pkg/pcm_out_pkg.sv
// Constants for the stereo PCM serial output block
package pcm_out_pkg;
    localparam int          VOICES        = 16;
    localparam int          SAMPLE_W      = 8;
    localparam int          WORD_W        = 16;
    localparam logic [7:0]  END_MARK      = 8'h80;
    localparam int          SYS_CLK_KHZ   = 12800;
    localparam int          FRAME_KHZ     = 50;
    // System clocks per frame, counted by the frame timer on the system clock
    localparam int          CLKS_PER_FRAME = SYS_CLK_KHZ / FRAME_KHZ;
    localparam int          BITS_PER_FRAME = 2 * WORD_W;
    localparam logic [15:0] MIX_RESET     = 16'h0000;
    // Port option: 0 selects the default pin order for clock, word clock, data
    localparam logic [1:0]  PIN_MAP_OPTION = 2'h0;
endpackage

// ===== rtl/pcm_voice_mixer.sv
// Mixer that sums sixteen signed 8-bit voices and flags end markers
`timescale 1ns/1ns
`default_nettype none
module pcm_voice_mixer #(
    parameter int VOICES = pcm_out_pkg::VOICES
) (
    input  wire logic                   ref_clk_in,
    input  wire logic                   rstn_in,
    input  wire logic                   sample_valid_in,
    input  wire logic [VOICES*8-1:0]    voice_samples_in,
    output logic      [15:0]            mix_out,
    output logic                        mix_valid_out,
    output logic      [VOICES-1:0]      section_end_out
);
    // ----------------------------------------
    // Mix arithmetic
    // ----------------------------------------
    logic [15:0]       mix_reg,   mix_next;
    logic              valid_reg, valid_next;
    logic [VOICES-1:0] end_reg,   end_next;

    function automatic logic [15:0] widen(input logic [7:0] s);
        widen = {{8{s[7]}}, s};
    endfunction

    always_comb begin
        mix_next   = mix_reg;
        end_next   = end_reg;
        valid_next = sample_valid_in;
        if (sample_valid_in) begin
            mix_next = pcm_out_pkg::MIX_RESET;
            for (int v = 0; v < VOICES; v++) begin
                // Marker is excluded from audio so it never clicks
                if (voice_samples_in[v*8 +: 8] == pcm_out_pkg::END_MARK) begin
                    end_next[v] = 1'b1;
                end else begin
                    end_next[v] = 1'b0;
                    mix_next = 16'(mix_next + widen(voice_samples_in[v*8 +: 8]));
                end
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mix_reg   <= 16'h0000;
            valid_reg <= 1'b0;
            end_reg   <= '0;
        end else begin
            mix_reg   <= mix_next;
            valid_reg <= valid_next;
            end_reg   <= end_next;
        end
    end

    assign mix_out         = mix_reg;
    assign mix_valid_out   = valid_reg;
    assign section_end_out = end_reg;
endmodule
`default_nettype wire

// ===== rtl/stereo_pcm_serial_output.sv
// Stereo serial audio output: mixer, frame timer, link-side serialiser
`timescale 1ns/1ns
`default_nettype none
module stereo_pcm_serial_output #(
    parameter int        VOICES        = pcm_out_pkg::VOICES,
    parameter int        CLKS_PER_FRAME = pcm_out_pkg::CLKS_PER_FRAME,
    parameter logic [1:0] PIN_MAP      = pcm_out_pkg::PIN_MAP_OPTION
) (
    input  wire logic                ref_clk_in,
    input  wire logic                rstn_in,
    input  wire logic                link_clk_in,
    input  wire logic [VOICES*8-1:0] voice_samples_in,
    output logic                     sample_request_out,
    output logic      [VOICES-1:0]   section_end_out,
    output logic                     serial_bit_clock_out,
    output logic      [2:0]          converter_port_pins_out
);
    // ----------------------------------------
    // Frame timer, system clock
    // ----------------------------------------
    localparam int CW = $clog2(CLKS_PER_FRAME);
    logic [CW-1:0] frame_cnt_reg, frame_cnt_next;
    logic          req_reg, req_next;
    logic [15:0]   mix;
    logic          mix_valid;

    always_comb begin
        req_next = 1'b0;
        if (frame_cnt_reg == CW'(CLKS_PER_FRAME - 1)) begin
            frame_cnt_next = '0;
            req_next = 1'b1;
        end else begin
            frame_cnt_next = CW'(frame_cnt_reg + 1'b1);
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            frame_cnt_reg <= '0;
            req_reg       <= 1'b0;
        end else begin
            frame_cnt_reg <= frame_cnt_next;
            req_reg       <= req_next;
        end
    end

    pcm_voice_mixer #(.VOICES(VOICES)) u_mixer (
        .ref_clk_in       (ref_clk_in),
        .rstn_in          (rstn_in),
        .sample_valid_in  (req_reg),
        .voice_samples_in (voice_samples_in),
        .mix_out          (mix),
        .mix_valid_out    (mix_valid),
        .section_end_out  (section_end_out)
    );

    // ----------------------------------------
    // Handshake crossing into link domain
    // ----------------------------------------
    // Same mix feeds both channels; left and right pan is outside this block
    logic [15:0] hold_reg,    hold_next;
    logic        tog_reg,     tog_next;
    logic        ack_s1_reg,  ack_s2_reg;
    logic        lrst_s1_reg, lrst_s2_reg;
    logic        ltog_s1_reg, ltog_s2_reg;
    logic        lack_reg,    lack_next;
    logic [15:0] lword_reg,   lword_next;
    logic [15:0] shift_reg,   shift_next;
    logic [4:0]  bit_reg,     bit_next;
    logic        ws_reg,      ws_next;
    logic        sd_reg,      sd_next;

    // Last bit slot of a channel word, where word clock and LSB move together
    function automatic logic word_last(input logic [4:0] cnt);
        word_last = (cnt[3:0] == 4'(pcm_out_pkg::WORD_W - 1));
    endfunction

    always_comb begin
        hold_next = hold_reg;
        tog_next  = tog_reg;
        // Drops a frame if the link has not taken the last one yet
        if (mix_valid && (tog_reg == ack_s2_reg)) begin
            hold_next = mix;
            tog_next  = ~tog_reg;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            hold_reg <= pcm_out_pkg::MIX_RESET;
            tog_reg  <= 1'b0;
        end else begin
            hold_reg <= hold_next;
            tog_reg  <= tog_next;
        end
    end

    // ----------------------------------------
    // Acknowledge return, system clock
    // ----------------------------------------
    // Two flops before the toggle compare; the first is read by nothing else
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ack_s1_reg <= 1'b0;
            ack_s2_reg <= 1'b0;
        end else begin
            ack_s1_reg <= lack_reg;
            ack_s2_reg <= ack_s1_reg;
        end
    end

    // ----------------------------------------
    // Link-side synchronisers
    // ----------------------------------------
    // Reset leaves asynchronously to the link clock, so link logic waits two edges
    // Only the toggle, the reset release and the returned acknowledge pass through synchronisers; the held word is never synchronised bit by bit
    always_ff @(negedge link_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lrst_s1_reg <= 1'b0;
            lrst_s2_reg <= 1'b0;
            ltog_s1_reg <= 1'b0;
            ltog_s2_reg <= 1'b0;
        end else begin
            lrst_s1_reg <= 1'b1;
            lrst_s2_reg <= lrst_s1_reg;
            ltog_s1_reg <= tog_reg;
            ltog_s2_reg <= ltog_s1_reg;
        end
    end

    // ----------------------------------------
    // Link-side word capture
    // ----------------------------------------
    // A word may be taken at any slot; the serialiser loads it only at a word start
    always_comb begin
        lack_next  = lack_reg;
        lword_next = lword_reg;
        if (lrst_s2_reg && (ltog_s2_reg != lack_reg)) begin
            lword_next = hold_reg;  // Stable: toggle seen only after hold settled
            lack_next  = ltog_s2_reg;
        end
    end

    always_ff @(negedge link_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lack_reg  <= 1'b0;
            lword_reg <= pcm_out_pkg::MIX_RESET;
        end else begin
            lack_reg  <= lack_next;
            lword_reg <= lword_next;
        end
    end

    // ----------------------------------------
    // Link-side serialiser
    // ----------------------------------------
    always_comb begin
        bit_next   = bit_reg;
        shift_next = shift_reg;
        ws_next    = ws_reg;
        sd_next    = sd_reg;
        // Held still until the reset release has been seen on this clock
        if (lrst_s2_reg) begin
            bit_next   = 5'(bit_reg + 1'b1);
            shift_next = {1'b0, shift_reg[15:1]};
            sd_next    = shift_reg[1];
            if (word_last(bit_reg)) begin
                // One word serves both channels until a pan stage exists
                ws_next    = ~bit_reg[4];
                shift_next = lword_reg;
                sd_next    = lword_reg[0];
            end
        end
    end

    // Changes on falling edge so converter samples on rising edge
    always_ff @(negedge link_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            shift_reg <= 16'h0000;
            bit_reg   <= 5'h00;
            ws_reg    <= 1'b0;
            sd_reg    <= 1'b0;
        end else begin
            shift_reg <= shift_next;
            bit_reg   <= bit_next;
            ws_reg    <= ws_next;
            sd_reg    <= sd_next;
        end
    end

    // ----------------------------------------
    // Converter pins
    // ----------------------------------------
    // Bit clock is the free-running link clock itself
    assign serial_bit_clock_out = link_clk_in;

    // Pin order fixed by parameter at build time only
    always_comb begin
        unique case (PIN_MAP)
            2'h0:    converter_port_pins_out = {sd_reg, ws_reg, link_clk_in};
            2'h1:    converter_port_pins_out = {link_clk_in, sd_reg, ws_reg};
            // Unused option codes fall back to the default order
            default: converter_port_pins_out = {sd_reg, ws_reg, link_clk_in};
        endcase
    end

    assign sample_request_out = req_reg;
endmodule
`default_nettype wire
